// ===== core/mpm_pkg.sv
// package: constants and types of the motion reporting and power management block
package mpm_pkg;
	localparam logic [6:0] ADDR_MOTION_STATUS = 7'h02;
	localparam logic [6:0] ADDR_DELTA_X = 7'h03;
	localparam logic [6:0] ADDR_DELTA_Y = 7'h04;
	localparam logic [6:0] ADDR_DISP_UPPER = 7'h0c;
	localparam logic [6:0] ADDR_MOUSE_CTRL = 7'h0d;
	localparam logic [6:0] ADDR_RUN_DOWNSHIFT = 7'h0e;
	localparam logic [6:0] ADDR_R1_PERIOD = 7'h0f;
	localparam logic [6:0] ADDR_R1_DOWNSHIFT = 7'h10;
	localparam logic [6:0] ADDR_R2_PERIOD = 7'h11;
	localparam logic [6:0] ADDR_R2_DOWNSHIFT = 7'h12;
	localparam logic [6:0] ADDR_R3_PERIOD = 7'h13;
	localparam logic [6:0] ADDR_MOTION_CTRL = 7'h21;
	localparam logic [7:0] RST_MOUSE_CTRL = 8'h01;
	localparam logic [7:0] RST_RUN_DOWNSHIFT = 8'h08;
	localparam logic [7:0] RST_R1_PERIOD = 8'h01;
	localparam logic [7:0] RST_R1_DOWNSHIFT = 8'h1f;
	localparam logic [7:0] RST_R2_PERIOD = 8'h09;
	localparam logic [7:0] RST_R2_DOWNSHIFT = 8'h2f;
	localparam logic [7:0] RST_R3_PERIOD = 8'h31;
	localparam logic [7:0] RST_MOTION_CTRL = 8'h00;
	localparam int MST_PENDING_BIT = 7;
	localparam int MC_REPORT12_BIT = 5;
	localparam int MOT_EDGE_BIT = 0;
	localparam int MOT_ACTLOW_BIT = 1;
	localparam int CLK_PERIOD_NS = 8;
	localparam int PULSE_NS = 380;
	localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
	localparam int PER_LSB_MS = 10;
	localparam int DS_RUN_LSB_MS = 100;
	localparam int DS_R1_LSB_MS = 320;
	localparam int DS_R2_LSB_MS = 12800;
	localparam int SPI_TIMEOUT_MS = 50;
	typedef enum logic [3:0] {
		MPM_RUN = 4'b0001,
		MPM_REST_LEVEL_ONE = 4'b0010,
		MPM_REST_LEVEL_TWO = 4'b0100,
		MPM_REST_LEVEL_THREE = 4'b1000
	} mpm_mode_type;
	typedef struct packed {
		logic valid;
		logic [11:0] dx;
		logic [11:0] dy;
	} mpm_motion_type;
endpackage : mpm_pkg

// ===== core/mpm_motion_power.sv
// motion reporting, power mode stepping, motion pin and two-wire register port
// Operation
// R1 - host starts every exchange, device only answers
// R2 - serial clock always comes from the host
// R3 - two lines: clock plus shared data line
// R4 - idle steps run, rest one, two, three
// R5 - downshift after configured motionless time
// R6 - rest level wakes within its period
// R7 - periods and downshift times writable 0x0e-0x13
// R8 - motion signalled on dedicated interrupt pin
// R9 - pin level or edge, high or low
// R10 - level mode pin follows pending flag
// R11 - full readout zeroes displacement, clears flag
// R12 - edge mode pulse on wake from rest
// R13 - flag set only with valid displacement data
// R14 - 12-bit reporting adds upper nibble register
// R15 - host reads until pending flag clears
// R16 - internal power-on reset, no external pin; the block takes its reset on the rst input port instead
// R17 - motion in rest returns to run, restarts timer
// R18 - pulse width counted in oscillator cycles
`timescale 1ns/1ps
`default_nettype none
module mpm_motion_power
	import mpm_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe,
	output logic motion_pin,
	input wire mpm_motion_type motion_in,
	output mpm_mode_type power_mode
);
	localparam int TW = $clog2(TICK_CYCLES);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
	localparam int PW_LATE = PULSE_CYC - 7;

	logic [2:0] sclk_sync_q;
	logic [1:0] sdio_sync_q;
	logic [TW-1:0] tick_cnt_q;
	logic tick;
	logic sclk_rise, sclk_fall, bit_in;
	logic [4:0] bit_cnt_q;
	logic [6:0] sh_in_q;
	logic [7:0] new_byte;
	logic [6:0] addr_q;
	logic is_write_q, rd_act_q;
	logic [7:0] out_sh_q;
	logic [5:0] sp_idle_q;
	logic addr_done, last_rise, wr_stb;
	logic [7:0] rd_data;
	logic [7:0] mouse_ctrl_q, run_ds_q, r1_per_q, r1_ds_q, r2_per_q, r2_ds_q, r3_per_q;
	logic [7:0] mot_ctl_q;
	logic [11:0] acc_x_q, acc_y_q;
	logic pending_q, motion_evt, clear_stb, report12;
	mpm_mode_type mode_q;
	logic [23:0] idle_q, ds_lim;
	logic [15:0] per_q, per_lim;
	logic seen_q, per_end, ds_hit, wake_stb;
	logic [5:0] pulse_cnt_q;
	logic pin_active, mot_edge, mot_low;

	// clock and data share the same synchroniser depth so they stay aligned [R2]
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			sclk_sync_q <= 3'h0;
			sdio_sync_q <= 2'h0;
		end
		else
		begin
			sclk_sync_q <= {sclk_sync_q[1:0], sclk};
			sdio_sync_q <= {sdio_sync_q[0], sdio_i};
		end

	assign sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
	assign sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2];
	assign bit_in = sdio_sync_q[1];

	always_ff @(posedge clk or posedge rst)
		if (rst)
			tick_cnt_q <= '0;
		else if (tick)
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick_cnt_q + TW'(1);
	assign tick = tick_cnt_q == TICK_LAST;

	assign new_byte = {sh_in_q, bit_in};
	assign addr_done = sclk_rise && bit_cnt_q == 5'h07;
	assign last_rise = sclk_rise && bit_cnt_q == 5'h0f;
	assign wr_stb = last_rise && is_write_q;

	// frame counter; a long quiet clock line drops a half-finished frame
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			bit_cnt_q <= 5'h00;
			sh_in_q <= 7'h00;
			addr_q <= 7'h00;
			is_write_q <= 1'b0;
			sp_idle_q <= 6'h00;
		end
		else
		begin
			if (sclk_rise || sclk_fall)
				sp_idle_q <= 6'h00;
			else if (tick && sp_idle_q != 6'(SPI_TIMEOUT_MS))
				sp_idle_q <= sp_idle_q + 6'h01;
			if (sclk_rise)
			begin
				sh_in_q <= new_byte[6:0];
				bit_cnt_q <= last_rise ? 5'h00 : bit_cnt_q + 5'h01; // [R3]
				if (addr_done)
				begin
					addr_q <= new_byte[6:0];
					is_write_q <= new_byte[7];
				end
			end
			else if (sp_idle_q == 6'(SPI_TIMEOUT_MS))
				bit_cnt_q <= 5'h00;
		end

	always_comb
	begin
		rd_data = 8'h00;
		if (new_byte[6:0] == ADDR_MOTION_STATUS)
			rd_data[MST_PENDING_BIT] = pending_q;
		else if (new_byte[6:0] == ADDR_DELTA_X)
			rd_data = acc_x_q[7:0];
		else if (new_byte[6:0] == ADDR_DELTA_Y)
			rd_data = acc_y_q[7:0];
		else if (new_byte[6:0] == ADDR_DISP_UPPER)
			rd_data = {acc_x_q[11:8], acc_y_q[11:8]}; // [R14]
		else if (new_byte[6:0] == ADDR_MOUSE_CTRL)
			rd_data = mouse_ctrl_q;
		else if (new_byte[6:0] == ADDR_RUN_DOWNSHIFT)
			rd_data = run_ds_q;
		else if (new_byte[6:0] == ADDR_R1_PERIOD)
			rd_data = r1_per_q;
		else if (new_byte[6:0] == ADDR_R1_DOWNSHIFT)
			rd_data = r1_ds_q;
		else if (new_byte[6:0] == ADDR_R2_PERIOD)
			rd_data = r2_per_q;
		else if (new_byte[6:0] == ADDR_R2_DOWNSHIFT)
			rd_data = r2_ds_q;
		else if (new_byte[6:0] == ADDR_R3_PERIOD)
			rd_data = r3_per_q;
		else if (new_byte[6:0] == ADDR_MOTION_CTRL)
			rd_data = mot_ctl_q;
	end

	// the data line is driven only inside a read the host has addressed [R1]
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			rd_act_q <= 1'b0;
			out_sh_q <= 8'h00;
			sdio_o <= 1'b0;
			sdio_oe <= 1'b0;
		end
		else if (addr_done && !new_byte[7])
		begin
			rd_act_q <= 1'b1;
			out_sh_q <= rd_data;
		end
		else if (last_rise || sp_idle_q == 6'(SPI_TIMEOUT_MS))
		begin
			rd_act_q <= 1'b0;
			sdio_oe <= 1'b0; // [R3]
		end
		else if (sclk_fall && rd_act_q)
		begin
			sdio_o <= out_sh_q[7];
			out_sh_q <= {out_sh_q[6:0], 1'b0};
			sdio_oe <= 1'b1;
		end

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			mouse_ctrl_q <= RST_MOUSE_CTRL;
			run_ds_q <= RST_RUN_DOWNSHIFT;
			r1_per_q <= RST_R1_PERIOD;
			r1_ds_q <= RST_R1_DOWNSHIFT;
			r2_per_q <= RST_R2_PERIOD;
			r2_ds_q <= RST_R2_DOWNSHIFT;
			r3_per_q <= RST_R3_PERIOD;
			mot_ctl_q <= RST_MOTION_CTRL;
		end
		else if (wr_stb)
		begin
			if (addr_q == ADDR_MOUSE_CTRL)
				mouse_ctrl_q <= new_byte;
			else if (addr_q == ADDR_RUN_DOWNSHIFT)
				run_ds_q <= new_byte; // [R7]
			else if (addr_q == ADDR_R1_PERIOD)
				r1_per_q <= new_byte; // [R7]
			else if (addr_q == ADDR_R1_DOWNSHIFT)
				r1_ds_q <= new_byte; // [R7]
			else if (addr_q == ADDR_R2_PERIOD)
				r2_per_q <= new_byte; // [R7]
			else if (addr_q == ADDR_R2_DOWNSHIFT)
				r2_ds_q <= new_byte; // [R7]
			else if (addr_q == ADDR_R3_PERIOD)
				r3_per_q <= new_byte; // [R7]
			else if (addr_q == ADDR_MOTION_CTRL)
				mot_ctl_q <= new_byte; // [R9]
		end

	assign report12 = mouse_ctrl_q[MC_REPORT12_BIT];
	assign motion_evt = motion_in.valid && (motion_in.dx != 12'h000 || motion_in.dy != 12'h000);
	// readout ends on the last displacement register of the chosen width [R14]
	assign clear_stb = addr_done && !new_byte[7]
		&& new_byte[6:0] == (report12 ? ADDR_DISP_UPPER : ADDR_DELTA_Y);

	// new motion in the clearing cycle is kept: it becomes the fresh sum [R11]
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			acc_x_q <= 12'h000;
			acc_y_q <= 12'h000;
			pending_q <= 1'b0;
		end
		else if (motion_evt)
		begin
			acc_x_q <= (clear_stb ? 12'h000 : acc_x_q) + motion_in.dx;
			acc_y_q <= (clear_stb ? 12'h000 : acc_y_q) + motion_in.dy;
			pending_q <= 1'b1; // [R13]
		end
		else if (clear_stb)
		begin
			acc_x_q <= 12'h000;
			acc_y_q <= 12'h000;
			pending_q <= 1'b0; // [R11]
		end

	always_comb
	begin
		ds_lim = '1;
		per_lim = (16'(r3_per_q) + 16'h0001) * 16'(PER_LSB_MS);
		case (mode_q)
			MPM_RUN: ds_lim = 24'(run_ds_q) * 24'(DS_RUN_LSB_MS); // [R5]
			MPM_REST_LEVEL_ONE:
			begin
				ds_lim = 24'(r1_ds_q) * 24'(DS_R1_LSB_MS); // [R5]
				per_lim = (16'(r1_per_q) + 16'h0001) * 16'(PER_LSB_MS);
			end
			MPM_REST_LEVEL_TWO:
			begin
				ds_lim = 24'(r2_ds_q) * 24'(DS_R2_LSB_MS); // [R5]
				per_lim = (16'(r2_per_q) + 16'h0001) * 16'(PER_LSB_MS);
			end
			default: ds_lim = '1;
		endcase
	end

	assign ds_hit = idle_q + 24'h000001 >= ds_lim;
	assign per_end = per_q + 16'h0001 >= per_lim;
	// rest levels only look at motion once per period, which sets the response time [R6]
	assign wake_stb = mode_q != MPM_RUN && tick && per_end && (seen_q || motion_evt);

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			mode_q <= MPM_RUN; // [R16]
			idle_q <= 24'h000000;
			per_q <= 16'h0000;
			seen_q <= 1'b0;
		end
		else
			case (mode_q)
				MPM_RUN:
					if (motion_evt)
						idle_q <= 24'h000000;
					else if (tick && ds_hit)
					begin
						mode_q <= MPM_REST_LEVEL_ONE; // [R4]
						idle_q <= 24'h000000;
						per_q <= 16'h0000;
						seen_q <= 1'b0;
					end
					else if (tick)
						idle_q <= idle_q + 24'h000001;
				default:
				begin
					if (motion_evt)
						seen_q <= 1'b1;
					if (wake_stb)
					begin
						mode_q <= MPM_RUN; // [R17]
						idle_q <= 24'h000000;
						per_q <= 16'h0000;
						seen_q <= 1'b0;
					end
					else if (tick && per_end && mode_q != MPM_REST_LEVEL_THREE && ds_hit)
					begin
						mode_q <= mode_q == MPM_REST_LEVEL_ONE ? MPM_REST_LEVEL_TWO : MPM_REST_LEVEL_THREE; // [R4]
						idle_q <= 24'h000000;
						per_q <= 16'h0000;
					end
					else if (tick)
					begin
						per_q <= per_end ? 16'h0000 : per_q + 16'h0001;
						idle_q <= idle_q + 24'h000001;
					end
				end
			endcase
	assign power_mode = mode_q;

	// pulse length counted in clock cycles, so it tracks the oscillator [R18]
	always_ff @(posedge clk or posedge rst)
		if (rst)
			pulse_cnt_q <= 6'h00;
		else if (wake_stb)
			pulse_cnt_q <= 6'(PULSE_CYC); // [R12]
		else if (pulse_cnt_q != 6'h00)
			pulse_cnt_q <= pulse_cnt_q - 6'h01;

	assign mot_edge = mot_ctl_q[MOT_EDGE_BIT];
	assign mot_low = mot_ctl_q[MOT_ACTLOW_BIT];
	assign pin_active = mot_edge ? pulse_cnt_q != 6'h00 : pending_q; // [R10]

	always_ff @(posedge clk or posedge rst)
		if (rst)
			motion_pin <= 1'b0;
		else
			motion_pin <= pin_active ^ mot_low; // [R8] [R9]

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_drive_only_in_read;
		sdio_oe |-> rd_act_q || $past(rd_act_q);
	endproperty
	a_drive_only_in_read: assert property (p_drive_only_in_read) else $error("data driven outside read"); // [R1]
	property p_release_after_frame;
		last_rise |=> !sdio_oe;
	endproperty
	a_release_after_frame: assert property (p_release_after_frame) else $error("data line not released"); // [R3]
	property p_step_order;
		$changed(mode_q) && mode_q != MPM_RUN |->
			($past(mode_q) == MPM_RUN && mode_q == MPM_REST_LEVEL_ONE)
			|| ($past(mode_q) == MPM_REST_LEVEL_ONE && mode_q == MPM_REST_LEVEL_TWO)
			|| ($past(mode_q) == MPM_REST_LEVEL_TWO && mode_q == MPM_REST_LEVEL_THREE);
	endproperty
	a_step_order: assert property (p_step_order) else $error("rest level skipped"); // [R4]
	property p_motion_holds_run;
		mode_q == MPM_RUN && motion_evt |=> mode_q == MPM_RUN && idle_q == 24'h000000;
	endproperty
	a_motion_holds_run: assert property (p_motion_holds_run) else $error("downshift despite motion"); // [R5]
	property p_wake_to_run;
		wake_stb |=> mode_q == MPM_RUN && idle_q == 24'h000000 && per_q == 16'h0000 && !seen_q;
	endproperty
	a_wake_to_run: assert property (p_wake_to_run) else $error("wake did not return to run"); // [R17]
	property p_level_pin;
		!mot_edge && !mot_low ##1 !mot_edge && !mot_low |-> motion_pin == $past(pending_q);
	endproperty
	a_level_pin: assert property (p_level_pin) else $error("level pin differs from flag"); // [R10]
	property p_clear;
		clear_stb && !motion_evt |=> !pending_q && acc_x_q == 12'h000 && acc_y_q == 12'h000;
	endproperty
	a_clear: assert property (p_clear) else $error("readout did not clear"); // [R11]
	property p_pulse;
		wake_stb && mot_edge && !mot_low && pulse_cnt_q == 6'h00 |->
			##2 motion_pin [*8] ##PW_LATE !motion_pin;
	endproperty
	a_pulse: assert property (p_pulse) else $error("wake pulse width wrong"); // [R12]
	property p_flag_cause;
		$rose(pending_q) |-> $past(motion_evt);
	endproperty
	a_flag_cause: assert property (p_flag_cause) else $error("flag set without data"); // [R13]
	property p_cfg_write;
		wr_stb && addr_q == ADDR_RUN_DOWNSHIFT |=> run_ds_q == $past(new_byte);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("downshift write lost"); // [R7]

	c_rest_level_three: cover property (mode_q == MPM_REST_LEVEL_THREE);
	c_wake: cover property (wake_stb && mot_edge);
	c_readout: cover property (clear_stb && pending_q);
	c_write: cover property (wr_stb);
endmodule : mpm_motion_power
`default_nettype wire

// ===== verification/mpm_host_model.sv
// host microcontroller model acting as master of the two-wire register port
`timescale 1ns/1ps
`default_nettype none
module mpm_host_model
(
	input wire logic sdio,
	output logic sclk,
	output logic sdio_o,
	output logic sdio_oe
);
	localparam realtime HALF = 62.5;

	// clock stands low between frames so the synchroniser sees no stray edge
	initial
	begin
		sclk = 1'b0;
		sdio_o = 1'b0;
		sdio_oe = 1'b0;
	end

	// one whole frame, address byte then data byte; only the host starts one
	task automatic xfer(input logic [7:0] hdr, input logic [7:0] wdata, output logic [7:0] rdata);
		logic [15:0] word;
		word = {hdr, wdata};
		rdata = 8'h00;
		for (int i = 15; i >= 0; i--)
		begin
			// read data phase: the host lets go so only the device drives the line
			sdio_oe = hdr[7] || (i > 7);
			sdio_o = word[i];
			#HALF sclk = 1'b1;
			if (i < 8)
				rdata[i] = sdio;
			#HALF sclk = 1'b0;
		end
		sdio_oe = 1'b0;
		#(2 * HALF);
	endtask : xfer

	// a frame broken off after a few bits; the device must drop it once the line goes quiet
	task automatic cut(input int nbits);
		for (int i = 0; i < nbits; i++)
		begin
			sdio_oe = 1'b1;
			sdio_o = 1'b1;
			#HALF sclk = 1'b1;
			#HALF sclk = 1'b0;
		end
		sdio_oe = 1'b0;
	endtask : cut
endmodule : mpm_host_model
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench of the motion reporting and power management block
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import mpm_pkg::*;
;
	logic clk = 1'b0;
	logic rst;
	logic sclk;
	logic host_o;
	logic host_oe;
	logic dev_o;
	logic dev_oe;
	logic sdio;
	logic motion_pin;
	mpm_motion_type motion_in;
	mpm_mode_type power_mode;
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int n;
	int w;
	// rows: {header byte, write data, expected read-back}
	logic [23:0] rows [21] = '{
		24'h0d0001, 24'h0e0008, 24'h0f0001, 24'h10001f, 24'h110009, 24'h12002f,
		24'h130031, 24'h210000, 24'h020000, 24'h030000, 24'h040000, 24'h0c0000,
		24'h300000, 24'h82ff00, 24'hb05500, 24'h8e0101, 24'h900101, 24'h8f0000,
		24'h910000, 24'h920000, 24'h930000};

	always #4 clk = ~clk;

	// pull-up holds the data line high when nobody drives it
	assign sdio = dev_oe ? dev_o : (host_oe ? host_o : 1'b1);

	mpm_motion_power #(.TICK_CYCLES(10)) i_mpm_motion_power (
		.clk(clk),
		.rst(rst),
		.sclk(sclk),
		.sdio_i(sdio),
		.sdio_o(dev_o),
		.sdio_oe(dev_oe),
		.motion_pin(motion_pin),
		.motion_in(motion_in),
		.power_mode(power_mode)
	);

	mpm_host_model i_mpm_host_model (
		.sdio(sdio),
		.sclk(sclk),
		.sdio_o(host_o),
		.sdio_oe(host_oe)
	);

	task automatic give_verdict();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic check_range(input string what, input int lo, input int hi, input int got);
		samples_checked++;
		if (got < lo || got > hi)
		begin
			num_errors++;
			$display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : check_range

	task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] unused;
		i_mpm_host_model.xfer({1'b1, a}, d, unused);
	endtask : reg_wr

	task automatic check_rd(input logic [6:0] a, input logic [7:0] exp, input string what);
		logic [7:0] got;
		i_mpm_host_model.xfer({1'b0, a}, 8'h00, got);
		check(what, {8'h00, exp}, {8'h00, got});
	endtask : check_rd

	task automatic move(input logic [11:0] x, input logic [11:0] y);
		@(posedge clk) #1 motion_in = '{1'b1, x, y};
		@(posedge clk) #1 motion_in.valid = 1'b0;
	endtask : move

	task automatic wait_mode(input mpm_mode_type m, output int cnt);
		cnt = 0;
		while (power_mode !== m && cnt < 20000)
			@(posedge clk) #1 cnt++;
	endtask : wait_mode

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			num_errors++;
			give_verdict();
		end
	end

	initial
	begin
		rst = 1'b1;
		motion_in = '0;
		repeat (20) @(posedge clk);
		#1 rst = 1'b0;
		check("reset state", {10'h000, MPM_RUN, 2'b00}, {10'h000, power_mode, motion_pin, dev_oe});
		repeat (4) @(posedge clk);
		for (int i = 0; i < 21; i++)
		begin
			if (rows[i][23])
				reg_wr(rows[i][22:16], rows[i][15:8]);
			check_rd(rows[i][22:16], rows[i][7:0], "register");
		end
		// level mode, active high, 8-bit reporting
		move(12'h005, 12'hffd);
		repeat (150) @(posedge clk);
		check_rd(ADDR_MOTION_STATUS, 8'h80, "pending");
		check("level pin", {15'h0000, motion_pin}, 16'h0001);
		check_rd(ADDR_DELTA_X, 8'h05, "x low");
		check_rd(ADDR_DELTA_Y, 8'hfd, "y low");
		check_rd(ADDR_MOTION_STATUS, 8'h00, "cleared");
		check_rd(ADDR_DELTA_X, 8'h00, "x zeroed");
		check("pin released", {15'h0000, motion_pin}, 16'h0000);
		// a sample without displacement must not raise the flag
		move(12'h000, 12'h000);
		repeat (150) @(posedge clk);
		check_rd(ADDR_MOTION_STATUS, 8'h00, "zero motion");
		reg_wr(ADDR_MOTION_CTRL, 8'h02);
		check("active low idle", {15'h0000, motion_pin}, 16'h0001);
		move(12'h001, 12'h001);
		repeat (150) @(posedge clk);
		check("active low set", {15'h0000, motion_pin}, 16'h0000);
		// 12-bit reporting, sums keep accumulating from the earlier sample
		reg_wr(ADDR_MOTION_CTRL, 8'h01);
		reg_wr(ADDR_MOUSE_CTRL, 8'h21);
		move(12'h123, 12'hffe);
		repeat (150) @(posedge clk);
		check_rd(ADDR_DELTA_X, 8'h24, "x12 low");
		check_rd(ADDR_DELTA_Y, 8'hff, "y12 low");
		check_rd(ADDR_MOTION_STATUS, 8'h80, "still pending");
		check_rd(ADDR_DISP_UPPER, 8'h1f, "upper nibbles");
		check_rd(ADDR_MOTION_STATUS, 8'h00, "12-bit cleared");
		// power stepping with shortened periods and downshift times
		wait_mode(MPM_REST_LEVEL_THREE, n);
		check_range("reach rest_level_three", 0, 6000, n);
		move(12'h001, 12'h000);
		wait_mode(MPM_RUN, n);
		check_range("wake rest_level_three", 0, 110, n);
		wait_mode(MPM_REST_LEVEL_ONE, n);
		check_range("run downshift", 980, 1010, n);
		wait_mode(MPM_REST_LEVEL_TWO, n);
		check_range("rest_level_one downshift", 3100, 3300, n);
		wait_mode(MPM_REST_LEVEL_THREE, n);
		check_range("rest_level_two downshift", 0, 110, n);
		move(12'h002, 12'h000);
		wait_mode(MPM_RUN, n);
		check_range("wake again", 0, 110, n);
		n = 0;
		while (motion_pin !== 1'b1 && n < 10)
			@(posedge clk) #1 n++;
		w = 0;
		while (motion_pin === 1'b1 && w < 100)
			@(posedge clk) #1 w++;
		check_range("edge pulse", PULSE_CYC, PULSE_CYC, w);
		// a half-finished frame must not shift the bit count of the next one
		i_mpm_host_model.cut(5);
		repeat (600) @(posedge clk);
		check_rd(ADDR_RUN_DOWNSHIFT, 8'h01, "after cut frame");
		// a reset in mid-run brings back the power-on state
		@(posedge clk) #1 rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		check("mid-run reset", {12'h000, MPM_RUN}, {12'h000, power_mode});
		repeat (4) @(posedge clk);
		check_rd(ADDR_RUN_DOWNSHIFT, RST_RUN_DOWNSHIFT, "mid-run reset regs");
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
